//--- sbl_pkg.sv
package sbl_pkg;
   // Clock rate and the sync window after reset.
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned SYNC_TIMEOUT_S = 6;
   localparam int unsigned SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_S * CLK_HZ;
   localparam int TMR_W = 28;
   // Stimulus pin selection.
   localparam int PIN_CNT = 32;
   localparam int PIN_IDX_W = 5;
   // Link sync pattern, sent first byte in the top lane.
   localparam int SYNC_LEN = 4;
   localparam logic [31:0] SYNC_PATTERN = 32'h5AA53CC3;
   // Signed packet command codes.
   localparam logic [7:0] CMD_PARAM_WRITE = 8'h01;
   localparam logic [7:0] CMD_PROG_LOAD = 8'h02;
   localparam logic [7:0] CMD_PROG_VERIFY = 8'h03;
   localparam logic [7:0] CMD_KEY_LOAD = 8'h04;
   localparam logic [7:0] CMD_BL_DISABLE = 8'h05;
   localparam logic [7:0] CMD_BL_REACTIVATE = 8'h06;
   localparam logic [7:0] CMD_LIFE_END = 8'h07;
   // Parameter write argument fields.
   localparam int ARG_PIN_LSB = 0;
   localparam int ARG_PIN_SET_BIT = 5;
   localparam int ARG_ALT_IF_BIT = 6;
   localparam int ARG_CRYPT_BIT = 7;
   // Data width and reset values.
   localparam int DATA_W = 32;
   localparam logic [31:0] KEY_RST = 32'h00000000;
   // Boot sequencer states.
   typedef enum logic [3:0] {
      ST_LOAD = 4'h0,
      ST_STIM = 4'h1,
      ST_SYNC = 4'h2,
      ST_SESSION = 4'h3,
      ST_VSTART = 4'h4,
      ST_VWAIT = 4'h5,
      ST_RUN = 4'h6,
      ST_SAFE = 4'h7,
      ST_DEAD = 4'h8
   } sbl_state_t;
endpackage

//--- sbl_sync_if.sv
`timescale 1ns/1ps
// Bytes from the default serial receiver and the match result.
interface sbl_sync_if;
   logic rx_valid;
   logic [7:0] rx_data;
   logic arm;
   logic hit;
   modport matcher(input rx_valid, input rx_data, input arm, output hit);
   modport seq(output rx_valid, output rx_data, output arm, input hit);
endinterface

//--- sbl_sync_match.sv
`timescale 1ns/1ps
// Watches received bytes for the link sync pattern while armed.
module sbl_sync_match
   import sbl_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Byte stream and result.
   sbl_sync_if.matcher sif
);
   // Number of pattern bytes matched so far.
   logic [1:0] idx_reg;
   logic [1:0] idx_next;
   // One-cycle pulse when the whole pattern has been seen.
   logic hit_reg;
   logic hit_next;
   logic [7:0] exp_byte;

   // The expected byte for the current position.
   assign exp_byte = SYNC_PATTERN[8 * (SYNC_LEN - 1 - int'(idx_reg)) +: 8];

   // Advance on a match; a mismatch may still start a new pattern.
   always_comb begin
      idx_next = idx_reg;
      hit_next = 1'b0;
      if (!sif.arm) begin
         idx_next = 2'h0;
      end else if (sif.rx_valid) begin
         if (sif.rx_data == exp_byte) begin
            if (idx_reg == 2'(SYNC_LEN - 1)) begin
               hit_next = 1'b1;
               idx_next = 2'h0;
            end else begin
               idx_next = idx_reg + 2'h1;
            end
         end else if (sif.rx_data == SYNC_PATTERN[31:24]) begin
            idx_next = 2'h1;
         end else begin
            idx_next = 2'h0;
         end
      end
   end

   // Register the matcher state.
   always_ff @(posedge clk) begin
      if (srst) begin
         idx_reg <= 2'h0;
         hit_reg <= 1'b0;
      end else begin
         idx_reg <= idx_next;
         hit_reg <= hit_next;
      end
   end

   assign sif.hit = hit_reg;
endmodule

//--- sbl_boot_seq.sv
`timescale 1ns/1ps
// Decides after every reset between bootloader session, secure boot and the dead state.
module sbl_boot_seq
   import sbl_pkg::*;
#(
   parameter int unsigned SYNC_TIMEOUT_CYCLES = SYNC_TIMEOUT_CYC
)(
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Persistent settings read back from nonvolatile storage.
   input wire logic nv_stim_assigned,
   input wire logic [PIN_IDX_W-1:0] nv_stim_idx,
   input wire logic nv_alt_if,
   input wire logic nv_bl_disabled,
   input wire logic nv_dev_phase,
   input wire logic nv_dead,
   // Candidate stimulus pins.
   input wire logic [PIN_CNT-1:0] stim_pins,
   // Bytes from the default serial receive line.
   input wire logic boot_rx_valid,
   input wire logic [7:0] boot_rx_data,
   // Parsed packets with their signature check result.
   input wire logic pkt_valid,
   input wire logic pkt_sig_ok,
   input wire logic pkt_from_default,
   input wire logic [7:0] pkt_cmd,
   input wire logic [DATA_W-1:0] pkt_arg,
   output logic pkt_ack,
   output logic pkt_rej,
   // Program memory signature check.
   output logic pm_verify_start,
   input wire logic pm_verify_done,
   input wire logic pm_verify_pass,
   // Boot outcome.
   output logic cpu_release,
   output logic safe_mode,
   output logic device_dead,
   output logic bl_session,
   // Updates for nonvolatile storage.
   output logic nv_wr,
   output logic nv_stim_assigned_out,
   output logic [PIN_IDX_W-1:0] nv_stim_idx_out,
   output logic nv_alt_if_out,
   output logic nv_bl_disabled_out,
   output logic nv_dead_out,
   // Program load toward external flash.
   output logic pm_wr_valid,
   output logic [DATA_W-1:0] pm_wr_data,
   // Memory crypt integrity unit.
   input wire logic core_supply_a_good,
   output logic crypt_enable,
   input wire logic fetch_valid,
   input wire logic [DATA_W-1:0] fetch_data,
   output logic fetch_out_valid,
   output logic [DATA_W-1:0] fetch_out_data
);
   localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(SYNC_TIMEOUT_CYCLES - 1);

   sbl_state_t state_reg, state_next; // Sequencer state.
   logic [TMR_W-1:0] tmr_reg, tmr_next; // Cycles since reset in the sync window.
   logic stim_set_reg, stim_set_next; // A stimulus pin is assigned.
   logic [PIN_IDX_W-1:0] stim_idx_reg, stim_idx_next; // Assigned pin.
   logic alt_reg, alt_next; // Non-default interfaces enabled.
   logic dis_reg, dis_next; // Bootloader disabled.
   logic dev_reg, dev_next; // Development phase.
   logic dead_reg, dead_next; // Device ended by life cycle.
   logic nvw_reg, nvw_next; // Storage update pulse.
   logic ack_reg, ack_next, rej_reg, rej_next; // Packet answer pulses.
   logic pmw_reg, pmw_next; // Program word write pulse.
   logic [DATA_W-1:0] pmd_reg, pmd_next; // Program word, encrypted if enabled.
   logic [DATA_W-1:0] key_reg, key_next; // Always-on key.
   logic cen_reg, cen_next; // Always-on crypt enable.
   logic fov_reg, fov_next; // Decrypted fetch valid.
   logic [DATA_W-1:0] fod_reg, fod_next; // Decrypted fetch data.
   logic sig_cmd; // A correctly signed packet in session.
   logic bl_allowed; // Bootloader may be entered or may write.

   sbl_sync_if sif();

   // Sync pattern matcher on the default serial receive line.
   sbl_sync_match u_match (
      .clk(clk),
      .srst(srst),
      .sif(sif)
   );
   assign sif.rx_valid = boot_rx_valid;
   assign sif.rx_data = boot_rx_data;
   assign sif.arm = (state_reg == ST_SYNC);

   assign sig_cmd = (state_reg == ST_SESSION) && pkt_valid && pkt_sig_ok;
   assign bl_allowed = !dis_reg || dev_reg;

   // Next state of the sequencer and its persistent settings.
   always_comb begin
      state_next = state_reg;
      tmr_next = tmr_reg;
      stim_set_next = stim_set_reg;
      stim_idx_next = stim_idx_reg;
      alt_next = alt_reg;
      dis_next = dis_reg;
      dev_next = dev_reg;
      dead_next = dead_reg;
      nvw_next = 1'b0;
      ack_next = 1'b0;
      rej_next = 1'b0;
      pmw_next = 1'b0;
      pmd_next = pmd_reg;
      case (state_reg)
         // Take the stored settings one cycle after reset.
         ST_LOAD: begin
            stim_set_next = nv_stim_assigned;
            stim_idx_next = nv_stim_idx;
            alt_next = nv_alt_if;
            dis_next = nv_bl_disabled;
            dev_next = nv_dev_phase;
            dead_next = nv_dead;
            tmr_next = '0;
            state_next = nv_dead ? ST_DEAD : ST_STIM;
         end
         // Choose between stimulus pin, sync watch and secure boot.
         ST_STIM: begin
            if (!bl_allowed) begin
               state_next = ST_VSTART;
            end else if (!stim_set_reg) begin
               state_next = ST_SYNC;
            end else if (stim_pins[stim_idx_reg]) begin
               state_next = ST_SESSION;
            end else begin
               state_next = ST_VSTART;
            end
         end
         // Wait for the sync pattern inside the window.
         ST_SYNC: begin
            tmr_next = tmr_reg + 1'b1;
            if (sif.hit) begin
               state_next = ST_SESSION;
            end else if (tmr_reg >= TMR_LAST) begin
               state_next = ST_VSTART;
            end
         end
         // Act on signed packets; refuse the rest.
         ST_SESSION: begin
            if (pkt_valid && !pkt_sig_ok) begin
               rej_next = 1'b1;
            end else if (sig_cmd) begin
               ack_next = 1'b1;
               case (pkt_cmd)
                  CMD_PARAM_WRITE: begin
                     if (pkt_from_default) begin
                        stim_set_next = pkt_arg[ARG_PIN_SET_BIT];
                        stim_idx_next = pkt_arg[ARG_PIN_LSB +: PIN_IDX_W];
                        alt_next = pkt_arg[ARG_ALT_IF_BIT];
                        nvw_next = 1'b1;
                     end else begin
                        ack_next = 1'b0;
                        rej_next = 1'b1;
                     end
                  end
                  CMD_PROG_LOAD: begin
                     if (bl_allowed) begin
                        pmw_next = 1'b1;
                        pmd_next = cen_reg ? (pkt_arg ^ key_reg) : pkt_arg;
                     end else begin
                        ack_next = 1'b0;
                        rej_next = 1'b1;
                     end
                  end
                  CMD_PROG_VERIFY: state_next = ST_VSTART;
                  CMD_KEY_LOAD: ack_next = 1'b1;
                  CMD_BL_DISABLE: begin
                     dis_next = 1'b1;
                     nvw_next = 1'b1;
                  end
                  CMD_BL_REACTIVATE: begin
                     if (dev_reg) begin
                        dis_next = 1'b0;
                        nvw_next = 1'b1;
                     end else begin
                        ack_next = 1'b0;
                        rej_next = 1'b1;
                     end
                  end
                  CMD_LIFE_END: begin
                     dead_next = 1'b1;
                     nvw_next = 1'b1;
                     state_next = ST_DEAD;
                  end
                  default: begin
                     ack_next = 1'b0;
                     rej_next = 1'b1;
                  end
               endcase
            end
         end
         // Launch the program memory signature check.
         ST_VSTART: state_next = ST_VWAIT;
         // Release or block customer code on the result.
         ST_VWAIT: begin
            if (pm_verify_done) begin
               state_next = pm_verify_pass ? ST_RUN : ST_SAFE;
            end
         end
         ST_RUN: state_next = ST_RUN;
         ST_SAFE: state_next = ST_SAFE;
         ST_DEAD: state_next = ST_DEAD;
         default: state_next = ST_LOAD;
      endcase
   end

   // Register the sequencer group.
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= ST_LOAD;
         tmr_reg <= '0;
         stim_set_reg <= 1'b0;
         stim_idx_reg <= '0;
         alt_reg <= 1'b0;
         dis_reg <= 1'b0;
         dev_reg <= 1'b0;
         dead_reg <= 1'b0;
         nvw_reg <= 1'b0;
         ack_reg <= 1'b0;
         rej_reg <= 1'b0;
         pmw_reg <= 1'b0;
         pmd_reg <= '0;
      end else begin
         state_reg <= state_next;
         tmr_reg <= tmr_next;
         stim_set_reg <= stim_set_next;
         stim_idx_reg <= stim_idx_next;
         alt_reg <= alt_next;
         dis_reg <= dis_next;
         dev_reg <= dev_next;
         dead_reg <= dead_next;
         nvw_reg <= nvw_next;
         ack_reg <= ack_next;
         rej_reg <= rej_next;
         pmw_reg <= pmw_next;
         pmd_reg <= pmd_next;
      end
   end

   // Always-on key store and the fetch decryption path.
   always_comb begin
      key_next = key_reg;
      cen_next = cen_reg;
      if (!core_supply_a_good) begin
         key_next = KEY_RST;
         cen_next = 1'b0;
      end else if (sig_cmd && pkt_cmd == CMD_KEY_LOAD) begin
         key_next = pkt_arg;
         cen_next = 1'b1;
      end else if (sig_cmd && pkt_cmd == CMD_PARAM_WRITE && pkt_from_default) begin
         cen_next = pkt_arg[ARG_CRYPT_BIT];
      end
      fov_next = fetch_valid && (state_reg == ST_RUN);
      fod_next = cen_reg ? (fetch_data ^ key_reg) : fetch_data;
   end

   // The key group is not touched by reset so it survives it.
   always_ff @(posedge clk) begin
      key_reg <= key_next;
      cen_reg <= cen_next;
      if (srst) begin
         fov_reg <= 1'b0;
         fod_reg <= '0;
      end else begin
         fov_reg <= fov_next;
         fod_reg <= fod_next;
      end
   end

   // Outputs, all from flip-flops or the state register.
   assign pm_verify_start = (state_reg == ST_VSTART);
   assign cpu_release = (state_reg == ST_RUN);
   assign safe_mode = (state_reg == ST_SAFE);
   assign device_dead = (state_reg == ST_DEAD);
   assign bl_session = (state_reg == ST_SESSION);
   assign pkt_ack = ack_reg;
   assign pkt_rej = rej_reg;
   assign nv_wr = nvw_reg;
   assign nv_stim_assigned_out = stim_set_reg;
   assign nv_stim_idx_out = stim_idx_reg;
   assign nv_alt_if_out = alt_reg;
   assign nv_bl_disabled_out = dis_reg;
   assign nv_dead_out = dead_reg;
   assign pm_wr_valid = pmw_reg;
   assign pm_wr_data = pmd_reg;
   assign crypt_enable = cen_reg;
   assign fetch_out_valid = fov_reg;
   assign fetch_out_data = fod_reg;

   stim_entry_a: assert property (@(posedge clk) disable iff (srst)
      state_reg == ST_STIM && bl_allowed && stim_set_reg && stim_pins[stim_idx_reg] |=> bl_session)
      else $error("Active stimulus pin did not open a session.");
   default_only_a: assert property (@(posedge clk) disable iff (srst)
      sig_cmd && pkt_cmd == CMD_PARAM_WRITE && !pkt_from_default
      |=> $stable(alt_reg) && $stable(stim_idx_reg) && pkt_rej)
      else $error("Parameter write accepted off the default interface.");
   secure_boot_a: assert property (@(posedge clk) disable iff (srst)
      state_reg == ST_STIM && bl_allowed && stim_set_reg && !stim_pins[stim_idx_reg]
      |=> pm_verify_start ##1 !cpu_release)
      else $error("Secure boot not started without session.");
   safe_fail_a: assert property (@(posedge clk) disable iff (srst)
      state_reg == ST_VWAIT && pm_verify_done && !pm_verify_pass |=> safe_mode [*3])
      else $error("Failed signature did not hold safe mode.");
   no_pin_a: assert property (@(posedge clk) disable iff (srst)
      state_reg == ST_STIM && bl_allowed && !stim_set_reg |=> sif.arm)
      else $error("Unassigned pin did not start sync watch.");
   sync_window_a: assert property (@(posedge clk) disable iff (srst)
      state_reg == ST_SYNC && !sif.hit && tmr_reg == TMR_LAST |=> pm_verify_start)
      else $error("Sync window end did not start secure boot.");
   sync_enter_a: assert property (@(posedge clk) disable iff (srst)
      state_reg == ST_SYNC && sif.hit |=> bl_session)
      else $error("Detected sync did not open a session.");
   sig_gate_a: assert property (@(posedge clk) disable iff (srst)
      pkt_valid && !pkt_sig_ok |=> !pm_wr_valid && !nv_wr && pkt_rej)
      else $error("Unsigned packet was acted on.");
   disable_load_a: assert property (@(posedge clk) disable iff (srst)
      dis_reg && !dev_reg |=> !pm_wr_valid)
      else $error("Program written while bootloader disabled.");
   reactivate_a: assert property (@(posedge clk) disable iff (srst)
      sig_cmd && pkt_cmd == CMD_BL_REACTIVATE && dev_reg |=> !nv_bl_disabled_out && nv_wr)
      else $error("Development reactivation failed.");
   dead_a: assert property (@(posedge clk) disable iff (srst)
      (device_dead || (sig_cmd && pkt_cmd == CMD_LIFE_END)) |=> device_dead && !fetch_out_valid && !pm_wr_valid)
      else $error("Ended device still runs.");
   decrypt_a: assert property (@(posedge clk) disable iff (srst)
      fetch_valid && cen_reg |=> fetch_out_data == ($past(fetch_data) ^ $past(key_reg)))
      else $error("Fetch not decrypted with key.");
   key_loss_a: assert property (@(posedge clk)
      !core_supply_a_good |=> key_reg == KEY_RST && !crypt_enable)
      else $error("Key survived supply loss.");
   release_a: assert property (@(posedge clk) disable iff (srst)
      state_reg == ST_VWAIT && pm_verify_done && pm_verify_pass |=> cpu_release)
      else $error("Passed check did not release processor.");
   cov_sync_c: cover property (@(posedge clk) disable iff (srst) state_reg == ST_SYNC ##1 bl_session);
   cov_run_c: cover property (@(posedge clk) disable iff (srst) pm_verify_start ##[1:50] cpu_release);
   cov_safe_c: cover property (@(posedge clk) disable iff (srst) $rose(safe_mode));
   cov_load_c: cover property (@(posedge clk) disable iff (srst) pm_wr_valid && crypt_enable);
endmodule

//--- sbl_host_model.sv
`timescale 1ns/1ps
// Host on the far side of the default serial link.
module sbl_host_model
   import sbl_pkg::*;
(
   // Clock.
   input wire logic clk,
   // Received bytes of the default line.
   output logic rx_valid,
   output logic [7:0] rx_data,
   // Parsed packets.
   output logic pkt_valid,
   output logic pkt_sig_ok,
   output logic pkt_from_default,
   output logic [7:0] pkt_cmd,
   output logic [DATA_W-1:0] pkt_arg
);
   // Lines start idle.
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      pkt_valid = 1'b0;
      pkt_sig_ok = 1'b0;
      pkt_from_default = 1'b0;
      pkt_cmd = 8'h00;
      pkt_arg = '0;
   end
   // Sends the sync pattern back to back, top lane first.
   task automatic send_sync();
      for (int i = SYNC_LEN - 1; i >= 0; i--) begin
         @(negedge clk);
         rx_valid = 1'b1;
         rx_data = SYNC_PATTERN[i*8 +: 8];
      end
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data = ~rx_data;
   endtask
   // Sends one packet; command and argument are inverted once released.
   task automatic send_pkt(input logic [7:0] cmd, input logic [31:0] arg, input logic sig, input logic dflt);
      @(negedge clk);
      pkt_valid = 1'b1;
      pkt_cmd = cmd;
      pkt_arg = arg;
      pkt_sig_ok = sig;
      pkt_from_default = dflt;
      @(negedge clk);
      pkt_valid = 1'b0;
      pkt_cmd = ~cmd;
      pkt_arg = ~arg;
   endtask
endmodule

//--- sbl_boot_seq_test.sv
`timescale 1ns/1ps
// Self-checking bench for the boot sequencer.
module sbl_boot_seq_test;
   import sbl_pkg::*;
   localparam int unsigned TO = 200; // Short sync window.
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic nv_stim_assigned, nv_alt_if, nv_bl_disabled, nv_dev_phase, nv_dead;
   logic [PIN_IDX_W-1:0] nv_stim_idx, nv_stim_idx_out;
   logic [PIN_CNT-1:0] stim_pins;
   logic boot_rx_valid, pkt_valid, pkt_sig_ok, pkt_from_default;
   logic [7:0] boot_rx_data, pkt_cmd;
   logic [31:0] pkt_arg, fetch_data, pm_wr_data, fetch_out_data, m_key, r;
   logic pm_verify_done, pm_verify_pass, core_supply_a_good, fetch_valid, pkt_ack, pkt_rej;
   logic pm_verify_start, cpu_release, safe_mode, device_dead, bl_session, nv_wr, nv_stim_assigned_out;
   logic nv_alt_if_out, nv_bl_disabled_out, nv_dead_out, pm_wr_valid, crypt_enable, fetch_out_valid;
   int err_count = 0, check_count = 0, cyc = 0, n;
   int m_dis, m_dev, m_crypt; // Bench model state.
   always #12.5 clk = ~clk;
   sbl_boot_seq #(.SYNC_TIMEOUT_CYCLES(TO)) i_sbl_boot_seq (.clk, .srst, .nv_stim_assigned, .nv_stim_idx,
      .nv_alt_if, .nv_bl_disabled, .nv_dev_phase, .nv_dead, .stim_pins, .boot_rx_valid, .boot_rx_data,
      .pkt_valid, .pkt_sig_ok, .pkt_from_default, .pkt_cmd, .pkt_arg, .pkt_ack, .pkt_rej, .pm_verify_start,
      .pm_verify_done, .pm_verify_pass, .cpu_release, .safe_mode, .device_dead, .bl_session, .nv_wr,
      .nv_stim_assigned_out, .nv_stim_idx_out, .nv_alt_if_out, .nv_bl_disabled_out, .nv_dead_out,
      .pm_wr_valid, .pm_wr_data, .core_supply_a_good, .crypt_enable, .fetch_valid, .fetch_data,
      .fetch_out_valid, .fetch_out_data);
   sbl_host_model i_sbl_host_model (.clk, .rx_valid(boot_rx_valid), .rx_data(boot_rx_data), .pkt_valid,
      .pkt_sig_ok, .pkt_from_default, .pkt_cmd, .pkt_arg);
   // Compares one value and counts it.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic results();
      $display("checks=%0d mismatches=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Cuts a hang short.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   // Resets with the given stored settings; pin is the level on the chosen candidate.
   task automatic boot(input logic sa, input logic dis, input logic dev, input logic pin);
      @(negedge clk);
      srst = 1'b1;
      nv_stim_assigned = sa;
      nv_stim_idx = r[4:0];
      nv_alt_if = r[9];
      nv_bl_disabled = dis;
      nv_dev_phase = dev;
      stim_pins = $urandom;
      stim_pins[r[4:0]] = pin;
      repeat (8) @(negedge clk);
      srst = 1'b0;
      m_dis = dis;
      m_dev = dev;
   endtask
   // Waits for a verify start, or a session when ses is set.
   task automatic wt(input logic ses);
      n = 0;
      while (!(pm_verify_start === 1'b1 || (ses && bl_session === 1'b1)) && n < 400) begin
         @(negedge clk);
         n++;
      end
   endtask
   // Answers a verify start with the given result.
   task automatic verify(input logic pass);
      @(negedge clk);
      pm_verify_done = 1'b1;
      pm_verify_pass = pass;
      @(negedge clk);
      pm_verify_done = 1'b0;
      pm_verify_pass = ~pass;
      chk(cpu_release, pass);
      chk(safe_mode, !pass);
   endtask
   // Sends a packet and compares the answer with the model.
   task automatic pkt(input logic [7:0] cmd, input logic [31:0] arg, input logic sig, input logic dflt);
      int ok;
      ok = 0;
      if (sig) begin
         case (cmd)
            CMD_PARAM_WRITE: ok = dflt;
            CMD_PROG_LOAD: ok = !(m_dis && !m_dev);
            CMD_BL_REACTIVATE: ok = m_dev;
            CMD_PROG_VERIFY, CMD_KEY_LOAD, CMD_BL_DISABLE, CMD_LIFE_END: ok = 1;
            default: ok = 0;
         endcase
      end
      i_sbl_host_model.send_pkt(cmd, arg, sig, dflt);
      chk(pkt_ack, ok);
      chk(pkt_rej, !ok);
      chk(pm_wr_valid, ok && cmd == CMD_PROG_LOAD);
      if (ok) begin
         case (cmd)
            CMD_PARAM_WRITE: begin
               chk({nv_wr, nv_stim_assigned_out, nv_alt_if_out, nv_stim_idx_out},
                  {1'b1, arg[5], arg[6], arg[4:0]});
               m_crypt = arg[7];
               chk(crypt_enable, m_crypt);
            end
            CMD_PROG_LOAD: chk(pm_wr_data, m_crypt ? arg ^ m_key : arg);
            CMD_KEY_LOAD: begin
               m_key = arg;
               m_crypt = 1;
            end
            CMD_BL_DISABLE: chk({nv_wr, nv_bl_disabled_out}, 2'b11);
            CMD_BL_REACTIVATE: chk({nv_wr, nv_bl_disabled_out}, 2'b10);
            default: ;
         endcase
         if (cmd == CMD_BL_DISABLE || cmd == CMD_BL_REACTIVATE) m_dis = (cmd == CMD_BL_DISABLE);
      end
   endtask
   // Passes one fetch word and compares the output.
   task automatic fetch(input logic en);
      @(negedge clk);
      fetch_valid = 1'b1;
      fetch_data = r;
      @(negedge clk);
      fetch_valid = 1'b0;
      fetch_data = ~r;
      chk(fetch_out_valid, en);
      if (en) chk(fetch_out_data, m_crypt ? r ^ m_key : r);
   endtask
   // Main sequence.
   initial begin
      void'($urandom(18));
      {nv_stim_assigned, nv_alt_if, nv_bl_disabled, nv_dev_phase, nv_dead, nv_stim_idx} = '0;
      {stim_pins, pm_verify_done, pm_verify_pass, core_supply_a_good, fetch_valid, fetch_data} = '0;
      {m_dis, m_dev, m_crypt, m_key} = '0;
      r = $urandom;
      boot(0, 0, 0, 0);
      core_supply_a_good = 1'b1;
      wt(1);
      chk(bl_session, 0);
      chk(n >= TO && n <= TO + 4, 1);
      verify(1);
      fetch(1);
      $display("test no-sync timeout done");
      boot(0, 0, 0, 0);
      repeat (3) @(negedge clk);
      i_sbl_host_model.send_sync();
      wt(1);
      chk(bl_session, 1);
      chk(n <= 3, 1);
      r = $urandom;
      pkt(CMD_PARAM_WRITE, {r[31:8], 2'b00, r[5:0]}, 0, 1);
      pkt(CMD_PARAM_WRITE, {r[31:8], 2'b00, r[5:0]}, 1, 0);
      pkt(CMD_PARAM_WRITE, {r[31:8], 2'b00, 1'b1, r[4:0]}, 1, 1);
      pkt(CMD_PROG_LOAD, $urandom, 1, 1);
      pkt(CMD_KEY_LOAD, $urandom, 1, 1);
      chk(crypt_enable, 1);
      pkt(CMD_PROG_LOAD, $urandom, 1, 1);
      pkt(8'h08, $urandom, 1, 1);
      pkt(CMD_BL_DISABLE, 0, 1, 1);
      pkt(CMD_PROG_LOAD, $urandom, 1, 1);
      pkt(CMD_BL_REACTIVATE, 0, 1, 1);
      pkt(CMD_PROG_VERIFY, 0, 1, 1);
      wt(0);
      chk(pm_verify_start, 1);
      verify(0);
      fetch(0);
      $display("test session and packets done");
      for (int p = 0; p < 2; p++) begin
         r = $urandom;
         boot(1, 0, 0, p[0]);
         wt(1);
         chk({bl_session, pm_verify_start}, p ? 2'b10 : 2'b01);
         chk(nv_alt_if_out, r[9]);
      end
      boot(1, 1, 0, 1);
      wt(1);
      chk({bl_session, pm_verify_start}, 2'b01);
      boot(1, 1, 1, 1);
      wt(1);
      chk(bl_session, 1);
      pkt(CMD_PROG_LOAD, $urandom, 1, 1);
      pkt(CMD_BL_REACTIVATE, 0, 1, 1);
      pkt(CMD_LIFE_END, 0, 1, 1);
      @(negedge clk);
      chk({device_dead, nv_dead_out, bl_session}, 3'b110);
      nv_dead = 1'b1;
      boot(0, 0, 0, 0);
      repeat (2) @(negedge clk);
      chk({device_dead, nv_dead_out, bl_session, pm_verify_start}, 4'b1100);
      $display("test stimulus pin and life cycle done");
      core_supply_a_good = 1'b0;
      @(negedge clk);
      chk(crypt_enable, 0);
      $display("test core supply loss done");
      results();
   end
endmodule
